/* hdl/rx_threshold_afc_rssi_regs.sv */
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module rx_threshold_afc_rssi_regs (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [rx_regs_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [rx_regs_pkg::DATA_W-1:0] pwdata_i,
    output logic [rx_regs_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Radio state and slicer timing
    input wire logic rx_mode_i,
    input wire logic chip_tick_i,
    input wire logic sub_tick_i,
    input wire logic [7:0] slice_level_i,
    output logic [8:0] slicer_threshold_o,
    // Measurement engines
    output logic corr_start_o,
    input wire rx_regs_pkg::word_result_t corr_result_i,
    output logic [15:0] correction_value_o,
    output logic error_start_o,
    input wire rx_regs_pkg::word_result_t error_result_i,
    output logic strength_start_o,
    input wire rx_regs_pkg::byte_result_t strength_result_i,
    // Interrupt
    output logic irq_o
);
    import rx_regs_pkg::*;

    // ***************************************************
    // Register state
    // ***************************************************
    thresh_type_t slicer_threshold_type, next_slicer_threshold_type;
    logic [2:0] peak_decrement_step, next_peak_decrement_step;
    logic [2:0] peak_decrement_period, next_peak_decrement_period;
    logic [1:0] average_filter_coeff, next_average_filter_coeff;
    logic [7:0] fixed_slicer_level, next_fixed_slicer_level;
    logic correction_autozero, next_correction_autozero;
    logic correction_on_rx_entry, next_correction_on_rx_entry;
    corr_state_t corr_state, next_corr_state;
    logic [15:0] correction_result, next_correction_result;
    logic error_measure_done, next_error_measure_done;
    logic [15:0] freq_error_result, next_freq_error_result;
    logic strength_done, next_strength_done;
    logic [7:0] strength_level, next_strength_level;
    logic [IRQ_W-1:0] irq_status, next_irq_status;
    logic [IRQ_W-1:0] irq_mask, next_irq_mask;
    logic [IRQ_W-1:0] irq_seen, next_irq_seen;
    logic rx_prev;
    logic [DATA_W-1:0] next_prdata;
    logic next_pready, next_pslverr, next_irq;
    logic next_corr_start, next_error_start, next_strength_start;
    logic setup, access, wr, rd, hit, rx_rise, corr_go;
    logic [5:0] idx;
    logic [7:0] rd_byte;
    logic [IRQ_W-1:0] events;

    assign idx = paddr_i[ADDR_W-1:2];
    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i && pready_o;
    assign wr = access && pwrite_i && !pslverr_o;
    assign rd = access && !pwrite_i && !pslverr_o;
    assign rx_rise = rx_mode_i && !rx_prev;

    // ***************************************************
    // Register file, measurement control and APB answer
    // ***************************************************

    // Next values of the register group
    always_comb begin
        next_slicer_threshold_type = slicer_threshold_type;
        next_peak_decrement_step = peak_decrement_step;
        next_peak_decrement_period = peak_decrement_period;
        next_average_filter_coeff = average_filter_coeff;
        next_fixed_slicer_level = fixed_slicer_level;
        next_correction_autozero = correction_autozero;
        next_correction_on_rx_entry = correction_on_rx_entry;
        next_corr_state = corr_state;
        next_correction_result = correction_result;
        next_error_measure_done = error_measure_done;
        next_freq_error_result = freq_error_result;
        next_strength_done = strength_done;
        next_strength_level = strength_level;
        next_irq_mask = irq_mask;
        next_irq_seen = irq_seen;
        next_prdata = prdata_o;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_corr_start = 1'b0;
        next_error_start = 1'b0;
        next_strength_start = 1'b0;
        corr_go = 1'b0;
        events = '0;
        hit = 1'b1;
        rd_byte = 8'h00;
        // Read multiplexer; unused bits and trigger bits read zero
        unique case (idx)
            IDX_OOK_PEAK: rd_byte = {slicer_threshold_type, peak_decrement_step, peak_decrement_period};
            IDX_OOK_AVG: rd_byte = {average_filter_coeff, 6'h00};
            IDX_OOK_FIX: rd_byte = fixed_slicer_level;
            IDX_CORR_CTRL: rd_byte = {1'b0, error_measure_done, 1'b0, corr_state == CORR_IDLE,
                                      correction_autozero, correction_on_rx_entry, 2'b00};
            IDX_CORR_HIGH: rd_byte = correction_result[15:8];
            IDX_CORR_LOW: rd_byte = correction_result[7:0];
            IDX_ERR_HIGH: rd_byte = freq_error_result[15:8];
            IDX_ERR_LOW: rd_byte = freq_error_result[7:0];
            IDX_STR_CTRL: rd_byte = {6'h00, strength_done, 1'b0};
            IDX_STR_RESULT: rd_byte = strength_level;
            IDX_IRQ_STATUS: rd_byte = {5'h00, irq_status};
            IDX_IRQ_MASK: rd_byte = {5'h00, irq_mask};
            default: hit = 1'b0;
        endcase
        // Setup phase: capture answer, ready in the access phase
        if (setup) begin
            next_pready = 1'b1;
            next_pslverr = !hit || (paddr_i[1:0] != 2'b00);
            next_prdata = {24'h000000, rd_byte};
            next_irq_seen = (idx == IDX_IRQ_STATUS && !pwrite_i) ? irq_status : '0;
        end
        // Measurement completions
        if (corr_state == CORR_BUSY && corr_result_i.finish) begin
            next_correction_result = corr_result_i.value;
            next_corr_state = CORR_IDLE;
            events[IRQ_CORR] = 1'b1;
        end
        if (!error_measure_done && error_result_i.finish) begin
            next_freq_error_result = error_result_i.value;
            next_error_measure_done = 1'b1;
            events[IRQ_ERROR] = 1'b1;
        end
        if (!strength_done && strength_result_i.finish) begin
            next_strength_level = strength_result_i.value;
            next_strength_done = 1'b1;
            events[IRQ_STRENGTH] = 1'b1;
        end
        // Register writes; trigger and zero bits act and are not stored
        if (wr) begin
            unique case (idx)
                IDX_OOK_PEAK: begin
                    next_slicer_threshold_type = thresh_type_t'(pwdata_i[TYPE_LSB +: 2]);
                    next_peak_decrement_step = pwdata_i[STEP_LSB +: 3];
                    next_peak_decrement_period = pwdata_i[PERIOD_LSB +: 3];
                end
                IDX_OOK_AVG: next_average_filter_coeff = pwdata_i[AVG_LSB +: 2];
                IDX_OOK_FIX: next_fixed_slicer_level = pwdata_i[7:0];
                IDX_CORR_CTRL: begin
                    next_correction_autozero = pwdata_i[AUTOZERO_BIT];
                    next_correction_on_rx_entry = pwdata_i[AUTO_BIT];
                    if (pwdata_i[CORR_TRIG_BIT]) begin
                        corr_go = 1'b1;
                    end
                    if (pwdata_i[ERR_TRIG_BIT]) begin
                        next_error_start = 1'b1;
                        next_error_measure_done = 1'b0;
                    end
                end
                IDX_STR_CTRL: begin
                    if (pwdata_i[STR_TRIG_BIT]) begin
                        next_strength_start = 1'b1;
                        next_strength_done = 1'b0;
                    end
                end
                IDX_IRQ_MASK: next_irq_mask = pwdata_i[IRQ_W-1:0];
                default: ;
            endcase
        end
        // Entry into receive mode starts a correction when enabled
        if (rx_rise && correction_on_rx_entry) begin
            corr_go = 1'b1;
        end
        if (corr_go) begin
            next_corr_start = 1'b1;
            next_corr_state = CORR_BUSY;
            if (correction_on_rx_entry && correction_autozero) begin
                next_correction_result = RST_CORR;
            end
        end
        // Zero command only counts while receiving
        if (wr && idx == IDX_CORR_CTRL && pwdata_i[ZERO_CMD_BIT] && rx_mode_i) begin
            next_correction_result = RST_CORR;
        end
        // Sticky status: read clears only what was shown, new events win
        next_irq_status = (irq_status & ~(rd && idx == IDX_IRQ_STATUS ? irq_seen : '0)) | events;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    // Register group flip-flops
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            slicer_threshold_type <= thresh_type_t'(RST_TYPE);
            peak_decrement_step <= RST_STEP;
            peak_decrement_period <= RST_PERIOD;
            average_filter_coeff <= RST_AVG;
            fixed_slicer_level <= RST_FIXED;
            correction_autozero <= 1'b0;
            correction_on_rx_entry <= 1'b0;
            corr_state <= CORR_IDLE;
            correction_result <= RST_CORR;
            error_measure_done <= 1'b0;
            freq_error_result <= RST_ERROR;
            strength_done <= 1'b1;
            strength_level <= RST_STRENGTH;
            irq_status <= '0;
            irq_mask <= '0;
            irq_seen <= '0;
            rx_prev <= 1'b0;
            prdata_o <= '0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            corr_start_o <= 1'b0;
            error_start_o <= 1'b0;
            strength_start_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            slicer_threshold_type <= next_slicer_threshold_type;
            peak_decrement_step <= next_peak_decrement_step;
            peak_decrement_period <= next_peak_decrement_period;
            average_filter_coeff <= next_average_filter_coeff;
            fixed_slicer_level <= next_fixed_slicer_level;
            correction_autozero <= next_correction_autozero;
            correction_on_rx_entry <= next_correction_on_rx_entry;
            corr_state <= next_corr_state;
            correction_result <= next_correction_result;
            error_measure_done <= next_error_measure_done;
            freq_error_result <= next_freq_error_result;
            strength_done <= next_strength_done;
            strength_level <= next_strength_level;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            irq_seen <= next_irq_seen;
            rx_prev <= rx_mode_i;
            prdata_o <= next_prdata;
            pready_o <= next_pready;
            pslverr_o <= next_pslverr;
            corr_start_o <= next_corr_start;
            error_start_o <= next_error_start;
            strength_start_o <= next_strength_start;
            irq_o <= next_irq;
        end
    end

    assign correction_value_o = correction_result;

    // ***************************************************
    // Slicer threshold
    // ***************************************************
    logic [3:0] dec_count, next_dec_count;
    logic [8:0] next_threshold;
    logic [15:0] avg_acc, next_avg_acc;
    logic dec_tick, tick_src;
    logic [3:0] dec_limit;
    logic [8:0] step, level9, floor9;
    logic [16:0] diff;
    logic [2:0] shift;

    // Next values of the slicer group
    always_comb begin
        level9 = {1'b0, slice_level_i};
        floor9 = {fixed_slicer_level, 1'b0};
        step = step_half_db(peak_decrement_step);
        // Chip-based periods for codes 0..3, sub-chip periods for 4..7
        if (!peak_decrement_period[2]) begin
            tick_src = chip_tick_i;
            dec_limit = 4'((5'h01 << peak_decrement_period[1:0]) - 5'h01);
        end else begin
            tick_src = sub_tick_i;
            // Shift amount widened so code 7 gives 16 >> 4 instead of wrapping to 16 >> 0
            dec_limit = 4'((SUB_TICKS_PER_CHIP >> ({1'b0, peak_decrement_period[1:0]} + 3'h1)) - 5'h01);
        end
        dec_tick = tick_src && (dec_count == dec_limit);
        next_dec_count = dec_count;
        if (tick_src) begin
            next_dec_count = dec_tick ? 4'h0 : dec_count + 4'h1;
        end
        // Averaging shift per cutoff code
        unique case (average_filter_coeff)
            2'h0: shift = 3'h5;
            2'h1: shift = 3'h3;
            2'h2: shift = 3'h2;
            default: shift = 3'h1;
        endcase
        diff = {1'b0, level9, 7'h00} - {1'b0, avg_acc};
        next_avg_acc = avg_acc;
        if (sub_tick_i) begin
            next_avg_acc = 16'($signed(diff) >>> shift) + avg_acc;
        end
        next_threshold = slicer_threshold_o;
        unique case (slicer_threshold_type)
            THR_FIXED: next_threshold = floor9;
            THR_PEAK: begin
                if (level9 > slicer_threshold_o) begin
                    next_threshold = level9;
                end else if (dec_tick) begin
                    // Compared at ten bits so a high floor plus a large step cannot wrap
                    next_threshold = ({1'b0, slicer_threshold_o} > {1'b0, floor9} + {1'b0, step})
                        ? slicer_threshold_o - step : floor9;
                end
            end
            THR_AVERAGE: next_threshold = avg_acc[15:7];
            default: ; // Reserved code holds the threshold
        endcase
    end

    // Slicer group flip-flops
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            dec_count <= 4'h0;
            avg_acc <= 16'h0000;
            slicer_threshold_o <= 9'h000;
        end else begin
            dec_count <= next_dec_count;
            avg_acc <= next_avg_acc;
            slicer_threshold_o <= next_threshold;
        end
    end

    // ***************************************************
    // Assertions
    // ***************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence wr_ctrl_s(int bit_n);
        wr && idx == IDX_CORR_CTRL && pwdata_i[bit_n];
    endsequence
    sequence rd_setup_s(logic [5:0] reg_idx);
        setup && !pwrite_i && idx == reg_idx && paddr_i[1:0] == 2'b00;
    endsequence

    corr_trigger_a: assert property (wr_ctrl_s(CORR_TRIG_BIT) |=> corr_start_o && corr_state == CORR_BUSY)
        else $error("correction trigger did not start a correction");
    error_trigger_a: assert property (wr_ctrl_s(ERR_TRIG_BIT) |=> error_start_o && !error_measure_done)
        else $error("error trigger did not clear done and pulse start");
    strength_trigger_a: assert property (wr && idx == IDX_STR_CTRL && pwdata_i[STR_TRIG_BIT]
        |=> strength_start_o && !strength_done ##1 !strength_start_o)
        else $error("strength trigger pulse wrong");
    strength_done_a: assert property (!strength_done && strength_result_i.finish && !(wr && idx == IDX_STR_CTRL)
        |=> strength_done && strength_level == $past(strength_result_i.value))
        else $error("strength result not taken on finish");
    trigger_reads_zero_a: assert property (rd_setup_s(IDX_CORR_CTRL) |=> prdata_o[1:0] == 2'h0 ##0 prdata_o[5] == 1'b0
        ##0 prdata_o[4] == $past(corr_state == CORR_IDLE))
        else $error("control readback wrong");
    rx_entry_a: assert property (rx_mode_i && !rx_prev && correction_on_rx_entry |=> corr_start_o)
        else $error("receive entry did not start correction");
    no_auto_a: assert property (rx_rise && !correction_on_rx_entry && !wr |=> !corr_start_o)
        else $error("correction started without trigger");
    autozero_a: assert property (corr_go && correction_on_rx_entry && correction_autozero
        |=> correction_result == 16'h0000)
        else $error("autozero did not clear correction");
    zero_cmd_a: assert property (wr_ctrl_s(ZERO_CMD_BIT) and rx_mode_i |=> correction_value_o == 16'h0000)
        else $error("zero command ignored in receive");
    error_read_a: assert property (rd_setup_s(IDX_ERR_HIGH) |=> prdata_o[7:0] == $past(freq_error_result[15:8]))
        else $error("error high byte readback wrong");
    fixed_level_a: assert property (slicer_threshold_type == THR_FIXED [*2] |-> slicer_threshold_o == $past(floor9))
        else $error("fixed threshold not applied");

endmodule // rx_threshold_afc_rssi_regs

`default_nettype wire

/* include/rx_regs_pkg.sv */
package rx_regs_pkg;

    // ***************************************************
    // Bus geometry and register indices (byte address = 4 x index)
    // ***************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [5:0] IDX_OOK_PEAK = 6'h1B;
    localparam logic [5:0] IDX_OOK_AVG = 6'h1C;
    localparam logic [5:0] IDX_OOK_FIX = 6'h1D;
    localparam logic [5:0] IDX_CORR_CTRL = 6'h1E;
    localparam logic [5:0] IDX_CORR_HIGH = 6'h1F;
    localparam logic [5:0] IDX_CORR_LOW = 6'h20;
    localparam logic [5:0] IDX_ERR_HIGH = 6'h21;
    localparam logic [5:0] IDX_ERR_LOW = 6'h22;
    localparam logic [5:0] IDX_STR_CTRL = 6'h23;
    localparam logic [5:0] IDX_STR_RESULT = 6'h24;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h30;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h31;

    // ***************************************************
    // Field positions
    // ***************************************************
    localparam int TYPE_LSB = 6;
    localparam int STEP_LSB = 3;
    localparam int PERIOD_LSB = 0;
    localparam int AVG_LSB = 6;
    localparam int ERR_DONE_BIT = 6;
    localparam int ERR_TRIG_BIT = 5;
    localparam int CORR_DONE_BIT = 4;
    localparam int AUTOZERO_BIT = 3;
    localparam int AUTO_BIT = 2;
    localparam int ZERO_CMD_BIT = 1;
    localparam int CORR_TRIG_BIT = 0;
    localparam int STR_DONE_BIT = 1;
    localparam int STR_TRIG_BIT = 0;
    localparam int IRQ_CORR = 0;
    localparam int IRQ_ERROR = 1;
    localparam int IRQ_STRENGTH = 2;
    localparam int IRQ_W = 3;

    // ***************************************************
    // Reset values
    // ***************************************************
    localparam logic [1:0] RST_TYPE = 2'h1;
    localparam logic [2:0] RST_STEP = 3'h0;
    localparam logic [2:0] RST_PERIOD = 3'h0;
    localparam logic [1:0] RST_AVG = 2'h2;
    localparam logic [7:0] RST_FIXED = 8'h06;
    localparam logic [15:0] RST_CORR = 16'h0000;
    localparam logic [15:0] RST_ERROR = 16'h0000;
    localparam logic [7:0] RST_STRENGTH = 8'hFF;

    // ***************************************************
    // Timing: sub-chip tick rate
    // ***************************************************
    localparam logic [4:0] SUB_TICKS_PER_CHIP = 5'h10;

    // ***************************************************
    // Types
    // ***************************************************
    typedef enum logic [1:0] {
        THR_FIXED = 2'b00,
        THR_PEAK = 2'b01,
        THR_AVERAGE = 2'b10,
        THR_RESERVED = 2'b11
    } thresh_type_t;

    typedef enum logic [1:0] {
        CORR_IDLE = 2'b01,
        CORR_BUSY = 2'b10
    } corr_state_t;

    typedef struct packed {
        logic finish;
        logic [15:0] value;
    } word_result_t;

    typedef struct packed {
        logic finish;
        logic [7:0] value;
    } byte_result_t;

    // Decrement size in half-dB units for each step code
    function automatic logic [8:0] step_half_db(input logic [2:0] code);
        logic [8:0] s;
        s = 9'h001;
        case (code)
            3'h0: s = 9'h001;
            3'h1: s = 9'h002;
            3'h2: s = 9'h003;
            3'h3: s = 9'h004;
            3'h4: s = 9'h006;
            3'h5: s = 9'h008;
            3'h6: s = 9'h00A;
            default: s = 9'h00C;
        endcase
        return s;
    endfunction

endpackage

/* testbench/meas_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Measurement engine stand-in: answers a start pulse with a finish pulse after DLY cycles
module meas_engine_model #(
    parameter int DLY = 20,
    parameter logic [15:0] VAL = 16'h0000
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    output logic finish_o,
    output logic [15:0] value_o
);
    int cnt;
    // Countdown; a restart reloads it
    always_ff @(posedge clk_i) begin
        finish_o <= 1'b0;
        if (!rstn_i) begin
            cnt <= 0;
        end else if (start_i) begin
            cnt <= DLY;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            finish_o <= (cnt == 1);
        end
    end
    // Value only meaningful with finish; inverted otherwise so stale data is not trusted
    assign value_o = finish_o ? VAL : ~VAL;
endmodule // meas_engine_model
`default_nettype wire

/* testbench/tb_rx_threshold_afc_rssi_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_rx_threshold_afc_rssi_regs;
    logic clk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, rx_mode_i = 0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic pready_o, pslverr_o, se, irq_o, cs, es, ss, cf, ef, sf;
    logic [15:0] cv, ev, sv, corr_o;
    logic tick_s = 0;
    logic [7:0] lvl = 8'h40;
    logic [8:0] thr;
    int err_total = 0, n_checks = 0, cyc = 0;
    // Rows: address, reset value, write data, readback after write
    logic [31:0] rows [12] = '{32'h6C40BFBF, 32'h70804040, 32'h7406A5A5, 32'h78100C1C,
        32'h7C00FF00, 32'h8000FF00, 32'h8400FF00, 32'h8800FF00, 32'h8C020002, 32'h90FF00FF,
        32'hC0000000, 32'hC4000707};
    rx_threshold_afc_rssi_regs rx_threshold_afc_rssi_regs_inst (.clk_i, .rstn_i, .psel_i, .penable_i,
        .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_mode_i,
        .chip_tick_i(1'b0), .sub_tick_i(tick_s), .slice_level_i(lvl), .slicer_threshold_o(thr),
        .corr_start_o(cs), .corr_result_i({cf, cv}), .correction_value_o(corr_o), .error_start_o(es),
        .error_result_i({ef, ev}), .strength_start_o(ss), .strength_result_i({sf, sv[7:0]}), .irq_o);
    meas_engine_model #(.DLY(20), .VAL(16'h1234)) meas_engine_model_c_inst (.clk_i, .rstn_i,
        .start_i(cs), .finish_o(cf), .value_o(cv));
    meas_engine_model #(.DLY(20), .VAL(16'hABCD)) meas_engine_model_e_inst (.clk_i, .rstn_i,
        .start_i(es), .finish_o(ef), .value_o(ev));
    meas_engine_model #(.DLY(20), .VAL(16'h005A)) meas_engine_model_s_inst (.clk_i, .rstn_i,
        .start_i(ss), .finish_o(sf), .value_o(sv));
    // One APB transfer: setup, access, hold until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        se = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Clock and cycle ceiling
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        foreach (rows[i]) begin
            rchk(rows[i][31:24], {24'h0, rows[i][23:16]});
            apb(1'b1, rows[i][31:24], {24'h0, rows[i][15:8]});
            rchk(rows[i][31:24], {24'h0, rows[i][7:0]});
        end
        $display("register table test done");
        rchk(8'hFC, 32'h0);
        chk({31'h0, se}, 32'h1);
        apb(1'b1, 8'h8C, 32'h01);
        rchk(8'h8C, 32'h00);
        repeat (30) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h1);
        rchk(8'h8C, 32'h02);
        rchk(8'h90, 32'h5A);
        rchk(8'hC0, 32'h04);
        chk({31'h0, irq_o}, 32'h0);
        $display("strength test done");
        apb(1'b1, 8'h78, 32'h2C);
        rchk(8'h78, 32'h1C);
        repeat (30) @(posedge clk_i);
        rchk(8'h78, 32'h5C);
        rchk(8'h84, 32'hAB);
        rchk(8'h88, 32'hCD);
        $display("error measure test done");
        rx_mode_i <= 1'b1;
        repeat (30) @(posedge clk_i);
        rchk(8'h7C, 32'h12);
        rchk(8'h80, 32'h34);
        chk({16'h0, corr_o}, 32'h1234);
        rx_mode_i <= 1'b0;
        @(posedge clk_i);
        rx_mode_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk({16'h0, corr_o}, 32'h0000);
        repeat (30) @(posedge clk_i);
        chk({16'h0, corr_o}, 32'h1234);
        rchk(8'hC0, 32'h03);
        apb(1'b1, 8'h78, 32'h0E);
        rchk(8'h7C, 32'h00);
        chk({16'h0, corr_o}, 32'h0000);
        apb(1'b1, 8'h78, 32'h08);
        rx_mode_i <= 1'b0;
        @(posedge clk_i);
        rx_mode_i <= 1'b1;
        repeat (30) @(posedge clk_i);
        rchk(8'hC0, 32'h00);
        apb(1'b1, 8'h78, 32'h09);
        rchk(8'h78, 32'h48);
        repeat (30) @(posedge clk_i);
        rchk(8'h78, 32'h58);
        rchk(8'h7C, 32'h12);
        rx_mode_i <= 1'b0;
        apb(1'b1, 8'h78, 32'h0A);
        rchk(8'h80, 32'h34);
        $display("correction test done");
        apb(1'b1, 8'h74, 32'h10);
        apb(1'b1, 8'h6C, 32'h00);
        @(posedge clk_i);
        chk({23'h0, thr}, 32'h020);
        apb(1'b1, 8'h6C, 32'h7F);
        @(posedge clk_i);
        chk({23'h0, thr}, 32'h040);
        lvl <= 8'h00;
        tick_s <= 1'b1;
        @(posedge clk_i);
        tick_s <= 1'b0;
        @(posedge clk_i);
        chk({23'h0, thr}, 32'h034);
        $display("slicer test done");
        rstn_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        rchk(8'h74, 32'h06);
        rchk(8'h78, 32'h10);
        rchk(8'h90, 32'hFF);
        $display("reset test done");
        wrap_up();
    end
endmodule // tb_rx_threshold_afc_rssi_regs
`default_nettype wire
